// ### core/scu_top.sv
// sequencing control: clock gate, counter, distributor, operation gates
`timescale 1ns/1ps
// Contract
// R01 - one clock pulse commands one sub-step
// R02 - manual step emits exactly one pulse
// R03 - fast and slow pulse rates provided
// R04 - single step pulses both lines
// R05 - pulse stream gated, stops on error/lag
// R06 - program counter is eleven bits wide
// R07 - counter adds one per completed operation
// R08 - counter drives bus, clears, loads bus
// R09 - wrap from all ones gives end pulse
// R10 - fetch pulses common, execute pulses decoded
// R11 - n bits decode to 2^n lines
// R12 - eight-way distributor routes pulse to selection
// R13 - start line one, advance after pulse
// R14 - after line eight return to one
// R15 - operation starts at first distributor pulse
// R16 - operation decoder asserts one of 32
// R17 - control is op AND phase, add-clear phase 1
// R18 - shared line: add-clear at phase 2
// R19 - same line: sub-clear at phase 3
// R20 - add or minus pulses at phase 4
// R21 - reset: phase one, counter zero, gate closed
module scu_top #(
  parameter int unsigned PC_WIDTH = scu_pkg::PC_W
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                resetn,
  // operator and stop controls
  input  wire logic                start_req,
  input  wire logic                stop_req,
  input  wire logic                step_req,
  input  wire logic                error_stop,
  input  wire logic                lag_stop,
  // order field and counter bus control
  input  wire logic [scu_pkg::OP_W-1:0] op_field,
  input  wire logic                pc_rd,
  input  wire logic                pc_clr,
  input  wire logic                pc_ld,
  input  wire logic [PC_WIDTH-1:0] bus_in,
  // bus and status outputs
  output logic [PC_WIDTH-1:0]      bus_out,
  output logic                     bus_out_en,
  output logic                     end_pulse,
  output logic                     op_start,
  output logic                     running,
  // clock lines out
  output logic                     slow_pulse,
  output logic                     fast_pulse,
  // time pulses and control lines
  output logic [scu_pkg::PHASES-1:0] time_pulse,
  output logic                     ctl_add_clr_p1,
  output logic                     ctl_shared_p23,
  output logic                     ctl_add_sub_p4
);
  typedef struct packed {
    logic [PC_WIDTH-1:0]              pc;
    logic [scu_pkg::PHASE_W-1:0]      phase;
    logic [scu_pkg::PHASES-1:0]       tp;
    logic [PC_WIDTH-1:0]              bus;
    logic                             bus_en;
    logic                             endp;
    logic                             start;
    logic                             run;
    logic                             slow;
    logic                             fast;
    logic                             c1;
    logic                             c23;
    logic                             c4;
  } scu_st_t;

  scu_st_t s_q, s_d;

  scu_tick_if tick ();
  logic                         run_w;
  logic [scu_pkg::PHASES-1:0]   ph_lines;
  logic [scu_pkg::OPS-1:0]      op_lines;
  logic [scu_pkg::PHASES-1:0]   gated;

  // master clock with manual step and stop gating
  scu_clock_gen u_clk (
    .clk        (clk),
    .resetn     (resetn),
    .start_req  (start_req),
    .stop_req   (stop_req),
    .step_req   (step_req),
    .error_stop (error_stop),
    .lag_stop   (lag_stop),
    .tick       (tick),
    .running    (run_w)
  );

  // distributor selector from its binary counter
  scu_decode #(.W(scu_pkg::PHASE_W)) u_ph (
    .sel   (s_q.phase),
    .lines (ph_lines)
  );

  // operation switch from the order's operation field
  scu_decode #(.W(scu_pkg::OP_W)) u_op (
    .sel   (op_field),
    .lines (op_lines)  // see R16
  );

  // slow pulse routed only to the selected phase line
  assign gated = ph_lines & {scu_pkg::PHASES{tick.slow_tick}}; // see R12 R01

  // next-state logic
  always_comb begin
    s_d        = s_q;
    s_d.tp     = gated;
    s_d.start  = gated[0]; // see R15
    s_d.endp   = 1'b0;
    s_d.run    = run_w;
    s_d.slow   = tick.slow_tick;
    s_d.fast   = tick.fast_tick;
    s_d.bus_en = pc_rd; // see R08
    s_d.bus    = pc_rd ? s_q.pc : s_q.bus;
    // distributor steps after each emitted pulse, wraps eight to one
    if (tick.slow_tick) begin
      s_d.phase = (s_q.phase == scu_pkg::PHASE_LAST) ?
                  scu_pkg::PHASE_RST : s_q.phase + 3'h1; // see R13 R14
    end
    // counter: clear beats load beats increment
    if (pc_clr) begin
      s_d.pc = '0; // see R08
    end else if (pc_ld) begin
      s_d.pc = bus_in; // see R08
    end else if (tick.slow_tick &&
                 s_q.phase == scu_pkg::PC_ADV_PHASE) begin
      s_d.pc = s_q.pc + PC_WIDTH'(1); // see R07 R06
      s_d.endp = (s_q.pc == {PC_WIDTH{1'b1}}); // see R09
    end
    // execute gates: op line AND phase; fetch pulses are tp itself
    s_d.c1  = op_lines[scu_pkg::OP_ADD_CLR] & gated[scu_pkg::PH1]; // see R17 R10
    s_d.c23 = (op_lines[scu_pkg::OP_ADD_CLR] & gated[scu_pkg::PH2]) | // see R18
              (op_lines[scu_pkg::OP_SUB_CLR] & gated[scu_pkg::PH3]); // see R19
    s_d.c4  = (op_lines[scu_pkg::OP_ADD] | op_lines[scu_pkg::OP_MINUS]) &
              gated[scu_pkg::PH4]; // see R20
  end

  // state register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q       <= '0;
      s_q.phase <= scu_pkg::PHASE_RST; // see R21
      s_q.pc    <= PC_WIDTH'(scu_pkg::PC_RST); // see R21
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign bus_out        = s_q.bus;
  assign bus_out_en     = s_q.bus_en;
  assign end_pulse      = s_q.endp;
  assign op_start       = s_q.start;
  assign running        = s_q.run;
  assign slow_pulse     = s_q.slow;
  assign fast_pulse     = s_q.fast;
  assign time_pulse     = s_q.tp;
  assign ctl_add_clr_p1 = s_q.c1;
  assign ctl_shared_p23 = s_q.c23;
  assign ctl_add_sub_p4 = s_q.c4;
endmodule

// ### core/scu_pkg.sv
// package of constants and types for the sequencing control unit
package scu_pkg;
  localparam int unsigned PC_W         = 11;
  localparam int unsigned PHASE_W      = 3;
  localparam int unsigned PHASES       = 8;
  localparam int unsigned OP_W         = 5;
  localparam int unsigned OPS          = 32;
  localparam int unsigned FAST_MULT    = 4;
  localparam logic [PC_W-1:0]    PC_RST    = 11'h000;
  localparam logic [PC_W-1:0]    PC_ONES   = 11'h7ff;
  localparam logic [PHASE_W-1:0] PHASE_RST = 3'h0;
  localparam logic [PHASE_W-1:0] PHASE_LAST = 3'h7;
  // operation codes (field of current order)
  localparam logic [OP_W-1:0] OP_ADD_CLR = 5'h01;
  localparam logic [OP_W-1:0] OP_SUB_CLR = 5'h02;
  localparam logic [OP_W-1:0] OP_ADD     = 5'h03;
  localparam logic [OP_W-1:0] OP_MINUS   = 5'h04;
  // phase on which the counter advances (last phase of the cycle)
  localparam logic [PHASE_W-1:0] PC_ADV_PHASE = 3'h7;
  // control phases, zero based: phase 1 is index 0
  localparam int unsigned PH1 = 0;
  localparam int unsigned PH2 = 1;
  localparam int unsigned PH3 = 2;
  localparam int unsigned PH4 = 3;
  localparam logic [1:0] FAST_CNT_RST = 2'h0;

  typedef enum logic [1:0] {
    SCU_STOPPED = 2'b00,
    SCU_RUN     = 2'b01,
    SCU_HALTED  = 2'b11
  } scu_gate_t;
endpackage

// ### core/scu_tick_if.sv
// interface carrying the gated clock pulses between modules
`timescale 1ns/1ps
interface scu_tick_if;
  logic slow_tick;
  logic fast_tick;
  modport src (output slow_tick, output fast_tick);
  modport dst (input slow_tick, input fast_tick);
endinterface

// ### core/scu_clock_gen.sv
// gated master clock with slow and fast pulse lines
`timescale 1ns/1ps
module scu_clock_gen (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // operator and stop controls
  input  wire logic start_req,
  input  wire logic stop_req,
  input  wire logic step_req,
  input  wire logic error_stop,
  input  wire logic lag_stop,
  // pulse outputs
  scu_tick_if.src   tick,
  output logic      running
);
  typedef struct packed {
    scu_pkg::scu_gate_t gate;
    logic [1:0]         fcnt;
    logic               slow;
    logic               fast;
  } scu_cg_st_t;

  scu_cg_st_t s_q, s_d;

  // gate control and pulse generation; fast line runs FAST_MULT per slow
  always_comb begin
    s_d      = s_q;
    s_d.slow = 1'b0;
    s_d.fast = 1'b0;
    case (s_q.gate)
      scu_pkg::SCU_STOPPED: begin
        if (start_req) begin
          s_d.gate = scu_pkg::SCU_RUN;
        end else if (step_req) begin
          s_d.slow = 1'b1; // see R02 R04
          s_d.fast = 1'b1; // see R04
        end
      end
      scu_pkg::SCU_RUN: begin
        if (error_stop || lag_stop) begin
          s_d.gate = scu_pkg::SCU_HALTED; // see R05
        end else if (stop_req) begin
          s_d.gate = scu_pkg::SCU_STOPPED; // see R05
        end else begin
          s_d.fast = 1'b1; // see R03
          s_d.fcnt = s_q.fcnt + 2'h1;
          s_d.slow = (s_q.fcnt == 2'(scu_pkg::FAST_MULT - 1)); // see R03
        end
      end
      scu_pkg::SCU_HALTED: begin
        // stays halted until restarted by the operator
        if (start_req) begin
          s_d.gate = scu_pkg::SCU_RUN;
        end else if (step_req) begin
          s_d.slow = 1'b1; // see R02
          s_d.fast = 1'b1;
        end
      end
      default: s_d.gate = scu_pkg::SCU_STOPPED;
    endcase
  end

  // state register; gate closed after reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q.gate <= scu_pkg::SCU_STOPPED; // see R21
      s_q.fcnt <= scu_pkg::FAST_CNT_RST;
      s_q.slow <= 1'b0;
      s_q.fast <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick.slow_tick = s_q.slow;
  assign tick.fast_tick = s_q.fast;
  assign running        = (s_q.gate == scu_pkg::SCU_RUN);
endmodule

// ### core/scu_decode.sv
// one-hot decoders for phase and operation field
`timescale 1ns/1ps
module scu_decode #(
  parameter int unsigned W = 3
) (
  // encoded state
  input  wire logic [W-1:0]      sel,
  // one-hot lines
  output logic [(1<<W)-1:0]      lines
);
  // exactly one line high per state combination
  genvar g;
  generate
    for (g = 0; g < (1 << W); g++) begin : g_line
      assign lines[g] = (sel == W'(g)); // see R11
    end
  endgenerate
endmodule

// ### bench/scu_sva.sv
// concurrent checks on the sequencing control ports
`timescale 1ns/1ps
module scu_sva (
  // clock, reset and controls
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       stop_req,
  input wire logic       step_req,
  input wire logic       error_stop,
  input wire logic       lag_stop,
  input wire logic [4:0] op_field,
  // outputs of the block
  input wire logic       running,
  input wire logic       slow_pulse,
  input wire logic       fast_pulse,
  input wire logic [7:0] time_pulse,
  input wire logic       ctl_add_clr_p1,
  input wire logic       ctl_shared_p23,
  input wire logic       ctl_add_sub_p4
);
  logic [7:0] last_q;
  logic [4:0] op_q;
  // previous phase and order, so each pulse is judged against its cause
  always_ff @(posedge clk) begin
    op_q <= op_field;
    if (!resetn) last_q <= 8'h80;
    else if (|time_pulse) last_q <= time_pulse;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence step_cmd; !running && step_req; endsequence
  sequence both_ticks; ##2 slow_pulse && fast_pulse; endsequence
  phase_onehot_a: assert property (
    |time_pulse |-> $onehot(time_pulse)) else $error("phase lines");
  phase_order_a: assert property (
    |time_pulse |-> time_pulse == {last_q[6:0], last_q[7]})
    else $error("phase order");
  step_pulse_a: assert property (
    step_cmd |-> both_ticks) else $error("step pulse");
  slow_gap_a: assert property (
    slow_pulse |=> !slow_pulse [*3]) else $error("slow rate");
  fast_run_a: assert property (
    (running && !error_stop && !lag_stop && !stop_req) [*4] |-> fast_pulse)
    else $error("fast rate");
  add_clr_a: assert property (
    ctl_add_clr_p1 == (time_pulse[0] && op_q == scu_pkg::OP_ADD_CLR))
    else $error("add clear line");
  shared_line_a: assert property (
    ctl_shared_p23 == (time_pulse[1] && op_q == scu_pkg::OP_ADD_CLR
      || time_pulse[2] && op_q == scu_pkg::OP_SUB_CLR)) else $error("shared");
  add_minus_a: assert property (
    ctl_add_sub_p4 == (time_pulse[3] && (op_q == scu_pkg::OP_ADD
      || op_q == scu_pkg::OP_MINUS))) else $error("add minus line");
endmodule

bind scu_top scu_sva i_scu_sva (.*);

// ### bench/scu_bus_model.sv
// bus side model: offers load values, catches counter reads
`timescale 1ns/1ps
module scu_bus_model (
  // clock and bench controls
  input wire logic        clk,
  input wire logic        drive,
  input wire logic [10:0] val,
  // counter side of the bus
  input wire logic        bus_out_en,
  input wire logic [10:0] bus_out,
  output logic     [10:0] bus_in = 11'h000,
  output logic     [10:0] rd = 11'h555 // a lost read cannot pass for zero
);
  // an undriven bus shows the inverse of its last value, never a hold
  always @(posedge clk) begin
    bus_in <= drive ? val : ~bus_in;
    if (bus_out_en) rd <= bus_out;
  end
endmodule

// ### bench/tb_top.sv
// self-checking bench for the sequencing control unit
`timescale 1ns/1ps
module tb_top;
  // block inputs, model controls and observed outputs
  logic        clk = 1'b0, resetn = 1'b0, start_req = 1'b0;
  logic        stop_req = 1'b0, step_req = 1'b0, error_stop = 1'b0;
  logic        lag_stop = 1'b0, pc_rd = 1'b0, pc_clr = 1'b0;
  logic        pc_ld = 1'b0, drive = 1'b0, bus_out_en, end_pulse;
  logic        op_start, running, slow_pulse, fast_pulse;
  logic        ctl_add_clr_p1, ctl_shared_p23, ctl_add_sub_p4;
  logic [4:0]  op_field = 5'h00;
  logic [7:0]  time_pulse;
  logic [10:0] val = 11'h000, bus_in, bus_out, rd;
  logic [15:0] g, e;
  int          fails = 0, samples_checked = 0, cyc = 0, ns = 0, nf = 0;
  int          ne = 0, s0, f0;

  scu_top i_scu_top (.*);
  scu_bus_model i_scu_bus_model (.*);
  // clock at 50 ns
  initial begin
    forever #25 clk = ~clk;
  end
  // pulses tallied at each edge; the ceiling cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ns <= ns + int'(slow_pulse);
    nf <= nf + int'(fast_pulse);
    ne <= ne + int'(end_pulse);
    if (cyc == 3000) begin
      fails++;
      summarize();
    end
  end
  task automatic chk(string n, logic [15:0] s, logic [15:0] x);
    samples_checked++;
    if (s !== x) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // one manual pulse; lines are sampled in the cycle they stand
  task automatic step();
    int s1, f1;
    @(posedge clk) step_req <= 1'b1;
    s1 = ns;
    f1 = nf;
    @(posedge clk) step_req <= 1'b0;
    @(posedge clk) #1 g = {4'h0, op_start, ctl_add_clr_p1, ctl_shared_p23,
      ctl_add_sub_p4, time_pulse};
    repeat (3) @(posedge clk);
    chk("step_slow", 16'(ns - s1), 16'h0001);
    chk("step_fast", 16'(nf - f1), 16'h0001);
  endtask
  // counter onto the bus, then compare what the model caught
  task automatic rd_pc(logic [10:0] x);
    @(posedge clk) pc_rd <= 1'b1;
    @(posedge clk) pc_rd <= 1'b0;
    repeat (2) @(posedge clk);
    chk("counter", {5'h00, rd}, {5'h00, x});
  endtask
  // order codes 0 to 5 at every phase, stepping by hand
  task automatic t_ops();
    for (int k = 0; k < 6; k++) begin
      @(posedge clk) op_field <= k[4:0];
      for (int p = 0; p < 8; p++) begin
        step();
        e = {12'h000, p == 0, k == 1 && p == 0,
          k == 1 && p == 1 || k == 2 && p == 2, (k == 3 || k == 4) && p == 3};
        chk("phase", {8'h00, g[7:0]}, 16'h0001 << p);
        chk("controls", {12'h000, g[11:8]}, e);
      end
    end
    $display("test ops done");
  endtask
  // wrap from all ones with an end pulse, one count per order, clear
  task automatic t_pc();
    @(posedge clk) drive <= 1'b1;
    val <= 11'h7ff;
    @(posedge clk) pc_ld <= 1'b1;
    @(posedge clk) pc_ld <= 1'b0;
    drive <= 1'b0;
    s0 = ne;
    repeat (8) step();
    chk("end_pulse", 16'(ne - s0), 16'h0001);
    rd_pc(11'h000);
    repeat (8) step();
    rd_pc(11'h001);
    @(posedge clk) pc_clr <= 1'b1;
    @(posedge clk) pc_clr <= 1'b0;
    rd_pc(11'h000);
    $display("test counter done");
  endtask
  // free run rates, then each stop source in turn closes the gate
  task automatic t_run();
    for (int k = 0; k < 3; k++) begin
      @(posedge clk) start_req <= 1'b1;
      @(posedge clk) start_req <= 1'b0;
      repeat (8) @(posedge clk);
      s0 = ns;
      f0 = nf;
      repeat (40) @(posedge clk);
      chk("slow_rate", 16'(ns - s0), 16'h000a);
      chk("fast_rate", 16'(nf - f0), 16'h0028);
      error_stop <= k == 0;
      lag_stop <= k == 1;
      stop_req <= k == 2;
      @(posedge clk) {error_stop, lag_stop, stop_req} <= 3'h0;
      repeat (6) @(posedge clk);
      f0 = nf;
      repeat (12) @(posedge clk);
      chk("halted", {15'h0000, running}, 16'h0000);
      chk("halt_fast", 16'(nf - f0), 16'h0000);
    end
    $display("test run done");
  endtask
  // reset in mid-run: gate, phase and counter all return to rest
  task automatic t_rst();
    @(posedge clk) start_req <= 1'b1;
    @(posedge clk) start_req <= 1'b0;
    repeat (8) @(posedge clk);
    chk("rst_run", {15'h0000, running}, 16'h0001);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    chk("rst_gate", {15'h0000, running}, 16'h0000);
    step();
    chk("rst_phase", {8'h00, g[7:0]}, 16'h0001);
    rd_pc(11'h000);
    $display("test reset done");
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rd_pc(11'h000);
    t_ops();
    t_pc();
    t_run();
    t_rst();
    summarize();
  end
endmodule
